//--- hdl/digital_pot_register_bank.sv
// Register bank and serial slave engine of a 128-tap digital pot
`timescale 1ns/1ns
module digital_pot_register_bank #(
	parameter int NV_WRITE_CYCLES = pot_pkg::NV_WRITE_CYCLES
) (
	input  wire logic       ref_clk,
	input  wire logic       reset,
	input  wire logic       scl,
	input  wire logic       sda_in,
	output wire logic       sda_out,
	output wire logic       sda_oe_n,
	input  wire logic       address_select_pin,
	output wire logic [6:0] wiper_position,
	output wire logic       shutdown_n,
	output wire logic       divider_mode,
	output wire logic       precision_off,
	output wire logic       nv_write_pending
);
	//----------------------------------------------------------
	// Declarations
	//----------------------------------------------------------
	nv_port_if   nv ();
	sda_drive_if pad ();

	logic                 scl_s1, scl_s2, scl_p;
	logic                 sda_s1, sda_s2, sda_p;
	logic                 sel_s1, sel_s2;
	logic                 scl_rise, start_det, stop_det;
	logic                 id_ok, drv_r, rw_r, pend_r;
	logic                 vsel_r, run_r, req_r, sel_r;
	logic                 commit, ready_r, recall_now;
	pot_pkg::link_state_e state_r;
	logic [3:0]           cnt_r;
	logic [7:0]           byte_in, sh_r, txs_r, rd_data;
	logic [7:0]           addr_r, wdata_r, rc_cnt_r;
	logic [6:0]           wiper_r;

	//----------------------------------------------------------
	// Submodules
	//----------------------------------------------------------
	nv_store #(
		.NV_WRITE_CYCLES (NV_WRITE_CYCLES)
	) u_store (
		.ref_clk (ref_clk),
		.reset   (reset),
		.nv      (nv.store)
	);

	sda_pad u_pad (
		.scl   (scl),
		.reset (reset),
		.drv   (pad.pad)
	);

	//----------------------------------------------------------
	// Pin synchronisers
	//----------------------------------------------------------
	// Two stages on each pin, plus a history stage for edges
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			scl_p  <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			sda_p  <= 1'b1;
			sel_s1 <= 1'b0;
			sel_s2 <= 1'b0;
		end else begin
			scl_s1 <= scl;
			scl_s2 <= scl_s1;
			scl_p  <= scl_s2;
			sda_s1 <= sda_in;
			sda_s2 <= sda_s1;
			sda_p  <= sda_s2;
			sel_s1 <= address_select_pin;
			sel_s2 <= sel_s1;
		end
	end

	// Bus events seen on synchronised levels
	assign scl_rise  = scl_s2 & ~scl_p;
	assign start_det = scl_s2 & scl_p & sda_p & ~sda_s2;
	assign stop_det  = scl_s2 & scl_p & ~sda_p & sda_s2;
	assign byte_in   = {sh_r[6:0], sda_s2};

	// Identification byte match
	assign id_ok = (byte_in[7:3] == pot_pkg::ID_PREFIX)
		&& (byte_in[pot_pkg::ID_SEL_BIT] == sel_s2)
		&& (byte_in[pot_pkg::ID_ZERO_BIT] == 1'b0);

	//----------------------------------------------------------
	// Read data selection
	//----------------------------------------------------------
	always_comb begin
		rd_data = 8'h00;
		case (addr_r)
			pot_pkg::ADDR_INIT: begin
				rd_data = vsel_r ? {1'b0, wiper_r} : nv.init_val;
			end
			pot_pkg::ADDR_MODE: begin
				rd_data = nv.mode_val & pot_pkg::MODE_WMASK;
			end
			pot_pkg::ADDR_ACCESS: begin
				rd_data[pot_pkg::ACC_VSEL_BIT] = vsel_r;
				rd_data[pot_pkg::ACC_RUN_BIT]  = run_r;
				rd_data[pot_pkg::ACC_BUSY_BIT] = nv.busy;
			end
			default: begin
				rd_data = 8'h00;
			end
		endcase
	end

	//----------------------------------------------------------
	// Serial protocol engine
	//----------------------------------------------------------
	// Byte framing, acknowledges and read shifting; drv_r plans the next low phase
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_r <= pot_pkg::ST_IDLE;
			cnt_r   <= 4'h0;
			sh_r    <= 8'h00;
			txs_r   <= 8'h00;
			drv_r   <= 1'b0;
			rw_r    <= 1'b0;
			pend_r  <= 1'b0;
			addr_r  <= 8'h00;
			wdata_r <= 8'h00;
		end else if (!ready_r) begin
			state_r <= pot_pkg::ST_IDLE;
			drv_r   <= 1'b0;
		end else if (start_det) begin
			state_r <= pot_pkg::ST_ID;
			cnt_r   <= 4'h0;
			drv_r   <= 1'b0;
			pend_r  <= 1'b0;
		end else if (stop_det) begin
			state_r <= pot_pkg::ST_IDLE;
			drv_r   <= 1'b0;
			pend_r  <= 1'b0;
		end else if (scl_rise && state_r != pot_pkg::ST_IDLE && state_r != pot_pkg::ST_SKIP) begin
			if (cnt_r != pot_pkg::BIT_ACK) begin
				sh_r  <= byte_in;
				cnt_r <= cnt_r + 4'h1;
				if (state_r == pot_pkg::ST_RD) begin
					txs_r <= {txs_r[6:0], 1'b0};
					drv_r <= (cnt_r == pot_pkg::BIT_LAST) ? 1'b0 : ~txs_r[6];
				end else if (cnt_r == pot_pkg::BIT_LAST) begin
					case (state_r)
						pot_pkg::ST_ID: begin
							drv_r <= id_ok;
							rw_r  <= byte_in[pot_pkg::ID_RW_BIT];
							if (!id_ok) begin
								state_r <= pot_pkg::ST_SKIP;
							end
						end
						pot_pkg::ST_ADDR: begin
							drv_r  <= 1'b1;
							addr_r <= byte_in;
						end
						pot_pkg::ST_WR: begin
							drv_r   <= 1'b1;
							wdata_r <= byte_in;
						end
						default: begin
							drv_r <= 1'b0;
						end
					endcase
				end
			end else begin
				cnt_r <= 4'h0;
				case (state_r)
					pot_pkg::ST_ID: begin
						if (rw_r) begin
							state_r <= pot_pkg::ST_RD;
							txs_r   <= rd_data;
							drv_r   <= ~rd_data[7];
						end else begin
							state_r <= pot_pkg::ST_ADDR;
							drv_r   <= 1'b0;
						end
					end
					pot_pkg::ST_ADDR: begin
						state_r <= pot_pkg::ST_WR;
						drv_r   <= 1'b0;
					end
					pot_pkg::ST_WR: begin
						state_r <= pot_pkg::ST_SKIP;
						pend_r  <= 1'b1;
						drv_r   <= 1'b0;
					end
					pot_pkg::ST_RD: begin
						if (!sda_s2) begin
							txs_r <= rd_data;
							drv_r <= ~rd_data[7];
						end else begin
							state_r <= pot_pkg::ST_SKIP;
							drv_r   <= 1'b0;
						end
					end
					default: begin
						drv_r <= 1'b0;
					end
				endcase
			end
		end
	end

	assign pad.drive_low = drv_r;

	//----------------------------------------------------------
	// Register writes, committed at stop
	//----------------------------------------------------------
	assign commit = stop_det & pend_r & ready_r;

	// Wiper and access control; store writes launch the self-timed cycle
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			wiper_r <= pot_pkg::WIPER_POWERUP;
			vsel_r  <= 1'b0;
			run_r   <= 1'b1;
			req_r   <= 1'b0;
			sel_r   <= 1'b0;
		end else begin
			req_r <= 1'b0;
			if (recall_now) begin
				wiper_r <= nv.init_val[6:0];
			end else if (commit && !nv.busy) begin
				case (addr_r)
					pot_pkg::ADDR_INIT: begin
						wiper_r <= wdata_r[6:0];
						req_r   <= ~vsel_r;
						sel_r   <= 1'b0;
					end
					pot_pkg::ADDR_MODE: begin
						req_r <= 1'b1;
						sel_r <= 1'b1;
					end
					pot_pkg::ADDR_ACCESS: begin
						vsel_r <= wdata_r[pot_pkg::ACC_VSEL_BIT];
						run_r  <= wdata_r[pot_pkg::ACC_RUN_BIT];
					end
					default: begin
						req_r <= 1'b0;
					end
				endcase
			end
		end
	end

	assign nv.wr_req  = req_r;
	assign nv.wr_sel  = sel_r;
	assign nv.wr_data = wdata_r;

	//----------------------------------------------------------
	// Power-up recall
	//----------------------------------------------------------
	// Hold the wiper at mid-scale, then copy in the stored position
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			rc_cnt_r <= 8'h00;
			ready_r  <= 1'b0;
		end else if (!ready_r) begin
			rc_cnt_r <= rc_cnt_r + 8'h01;
			ready_r  <= recall_now;
		end
	end

	assign recall_now = ~ready_r & (rc_cnt_r == pot_pkg::RECALL_LAST);

	//----------------------------------------------------------
	// Outputs
	//----------------------------------------------------------
	assign sda_oe_n         = pad.oe_n;
	assign sda_out          = pad.out;
	assign wiper_position   = wiper_r;
	assign shutdown_n       = run_r;
	assign divider_mode     = nv.mode_val[pot_pkg::MODE_DIV_BIT];
	assign precision_off    = nv.mode_val[pot_pkg::MODE_PREC_BIT];
	assign nv_write_pending = nv.busy;

	//----------------------------------------------------------
	// Assertions
	//----------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	sequence id_end_bad;
		ready_r && !start_det && !stop_det && scl_rise && state_r == pot_pkg::ST_ID
			&& cnt_r == pot_pkg::BIT_LAST && !id_ok;
	endsequence

	sequence addr_end;
		ready_r && !start_det && !stop_det && scl_rise && state_r == pot_pkg::ST_ADDR
			&& cnt_r == pot_pkg::BIT_LAST;
	endsequence

	sequence nv_launch;
		commit && !nv.busy && addr_r == pot_pkg::ADDR_INIT && !vsel_r;
	endsequence

	a_powerup_wiper: assert property (
		!ready_r |-> wiper_r == pot_pkg::WIPER_POWERUP) else $error("wiper not mid-scale at power-up");

	a_recall_value: assert property (
		$rose(ready_r) |-> wiper_r == nv.init_val[6:0]) else $error("store not recalled to wiper");

	a_store_mirror: assert property (
		nv.wr_req && !nv.wr_sel |-> wiper_r == nv.wr_data[6:0]) else $error("wiper missed store write");

	a_stop_launch: assert property (
		nv_launch |=> nv.wr_req ##1 nv.busy) else $error("store write not launched at stop");

	a_pending_set: assert property (
		nv.wr_req |=> nv.busy && (addr_r != pot_pkg::ADDR_ACCESS || rd_data[pot_pkg::ACC_BUSY_BIT]))
		else $error("pending flag not set");

	a_pending_locks: assert property (
		commit && nv.busy |=> $stable(vsel_r) && $stable(run_r) && $stable(wiper_r))
		else $error("write accepted while pending");

	a_id_reject: assert property (
		id_end_bad |=> state_r == pot_pkg::ST_SKIP && !drv_r) else $error("foreign id acknowledged");

	a_addr_ack: assert property (
		addr_end |=> drv_r && addr_r == $past(byte_in)) else $error("address byte not acknowledged");

	a_mode_reserved: assert property (
		addr_r == pot_pkg::ADDR_MODE |-> rd_data[5:0] == 6'h00) else $error("reserved mode bits visible");

	a_access_zero: assert property (
		addr_r == pot_pkg::ADDR_ACCESS |-> rd_data[4:0] == 5'h00) else $error("access low bits not zero");
endmodule

//--- hdl/pot_pkg.sv
// Constants, types and timing for the digital pot register bank
//--------------------------------------------------------------
// Behaviour
//--------------------------------------------------------------
// Behaviour
// - Wiper is a 7-bit tap position, 00h low end, 7Fh high end.
// - Wiper is 40h during power-up, then reloaded from the initial-position store.
// - Initial-position store leaves the factory holding 40h.
// - Address 0 is store/wiper, 1 is mode select, 2 is access control.
// - Access bit 7 set reaches the wiper only; clear reaches the store. Resets 0.
// - A write to the store also loads the wiper.
// - Access bit 6 clear puts the pot in shutdown; resets to 1.
// - Access bit 5 reads 1 while a non-volatile write runs.
// - While that flag is set, wiper and access-control writes are refused.
// - Mode bit 7 clear selects rheostat, set selects divider; resets 0.
// - Mode bit 6 set turns resistance matching off; resets 0.
// - Mode bits 5 to 0 ignore writes; master ignores their read value.
// - Store contents survive power-down and are recalled at power-up.
// - Slave answers only when its select bit matches the select pin.
// - Data sampled on serial clock rise, driven open-drain after its fall.
// - Identification byte is 01010, select bit, 0, then read/write.
// - Write is start, id, address, one data byte, stop; all three acked.
// - Non-volatile write starts after stop; master waits 20 ms before the next.
// - Read is id, address, repeated start, read id, bytes while master acks.
package pot_pkg;
	// Register addresses
	localparam logic [7:0] ADDR_INIT   = 8'h00;
	localparam logic [7:0] ADDR_MODE   = 8'h01;
	localparam logic [7:0] ADDR_ACCESS = 8'h02;

	// Reset and shipping values
	localparam logic [6:0] WIPER_POWERUP = 7'h40;
	localparam logic [7:0] STORE_SHIP    = 8'h40;
	localparam logic [7:0] MODE_SHIP     = 8'h00;

	// Field positions
	localparam int ACC_VSEL_BIT  = 7;
	localparam int ACC_RUN_BIT   = 6;
	localparam int ACC_BUSY_BIT  = 5;
	localparam int MODE_DIV_BIT  = 7;
	localparam int MODE_PREC_BIT = 6;
	localparam logic [7:0] MODE_WMASK = 8'hc0;

	// Identification byte
	localparam logic [4:0] ID_PREFIX   = 5'h0a;
	localparam int         ID_SEL_BIT  = 2;
	localparam int         ID_ZERO_BIT = 1;
	localparam int         ID_RW_BIT   = 0;

	// Bit counter marks
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_ACK  = 4'h8;

	// Timing
	localparam int CLK_MHZ         = 50;
	localparam int NV_WRITE_MS     = 20;
	localparam int NV_WRITE_CYCLES = NV_WRITE_MS * CLK_MHZ * 1000;
	localparam int NV_CNT_W        = 20;
	localparam int RECALL_NS       = 1000;
	localparam int RECALL_CYCLES   = (RECALL_NS * CLK_MHZ + 999) / 1000;
	localparam logic [7:0] RECALL_LAST = 8'(RECALL_CYCLES - 1);

	// Serial protocol states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ID,
		ST_ADDR,
		ST_WR,
		ST_RD,
		ST_SKIP
	} link_state_e;
endpackage

//--- hdl/pot_if.sv
// Interfaces between the register bank, the store and the pad stage
`timescale 1ns/1ns

// Non-volatile store port
interface nv_port_if;
	logic       wr_req;
	logic       wr_sel;
	logic [7:0] wr_data;
	logic       busy;
	logic [7:0] init_val;
	logic [7:0] mode_val;
	modport bank  (output wr_req, wr_sel, wr_data, input busy, init_val, mode_val);
	modport store (input wr_req, wr_sel, wr_data, output busy, init_val, mode_val);
endinterface

// Serial data pad drive
interface sda_drive_if;
	logic drive_low;
	logic oe_n;
	logic out;
	modport engine (output drive_low, input oe_n, out);
	modport pad    (input drive_low, output oe_n, out);
endinterface

//--- hdl/nv_store.sv
// Self-timed non-volatile store for initial position and mode select
`timescale 1ns/1ns
module nv_store #(
	parameter int NV_WRITE_CYCLES = pot_pkg::NV_WRITE_CYCLES
) (
	input wire logic  ref_clk,
	input wire logic  reset,
	nv_port_if.store  nv
);
	localparam int W = pot_pkg::NV_CNT_W;

	// Contents carry no reset so they survive a power cycle
	logic [7:0]   init_r = pot_pkg::STORE_SHIP;
	logic [7:0]   mode_r = pot_pkg::MODE_SHIP;
	logic         busy_r;
	logic [W-1:0] cnt_r;

	// Latch new contents on request
	always_ff @(posedge ref_clk) begin
		if (nv.wr_req && !busy_r && !nv.wr_sel) begin
			init_r <= nv.wr_data;
		end
		if (nv.wr_req && !busy_r && nv.wr_sel) begin
			mode_r <= nv.wr_data & pot_pkg::MODE_WMASK;
		end
	end

	// Self-timed write cycle
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			busy_r <= 1'b0;
			cnt_r  <= '0;
		end else if (nv.wr_req && !busy_r) begin
			busy_r <= 1'b1;
			cnt_r  <= W'(NV_WRITE_CYCLES - 1);
		end else if (busy_r) begin
			if (cnt_r == '0) begin
				busy_r <= 1'b0;
			end
			cnt_r <= cnt_r - W'(1);
		end
	end

	assign nv.busy     = busy_r;
	assign nv.init_val = init_r;
	assign nv.mode_val = mode_r;

	// Busy stays up for at least the first 8 cycles of the write cycle
	a_busy_holds: assert property (@(posedge ref_clk) disable iff (reset)
		$rose(busy_r) |-> busy_r [*8]) else $error("write cycle ended early");
endmodule

//--- hdl/sda_pad.sv
// Open-drain data output stage clocked by the serial clock
`timescale 1ns/1ns
module sda_pad (
	input wire logic  scl,
	input wire logic  reset,
	sda_drive_if.pad  drv
);
	logic oe_n_r;
	logic out_r;

	// New level taken after each falling serial clock edge; the plan is stable across the low phase
	always_ff @(negedge scl or posedge reset) begin
		if (reset) begin
			oe_n_r <= 1'b1;
		end else begin
			oe_n_r <= ~drv.drive_low;
		end
	end

	// Open drain only ever pulls low
	always_ff @(negedge scl or posedge reset) begin
		if (reset) begin
			out_r <= 1'b0;
		end else begin
			out_r <= 1'b0;
		end
	end

	assign drv.oe_n = oe_n_r;
	assign drv.out  = out_r;
endmodule

//--- verif/pot_bus_master.sv
// Serial bus master model that owns the clock and drives data open-drain
`timescale 1ns/1ns
module pot_bus_master #(
	parameter int HALF_NS = 150
) (
	output logic      scl,
	output logic      sda_low,
	input  wire logic sda
);
	//------------------------------------------------------
	// Bus sequencing
	//------------------------------------------------------
	// Idle bus: clock parked high, data released to the pull-up
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// Start or repeated start: data falls while the clock is high
	task automatic start();
		#(HALF_NS * 2 / 3) sda_low = 1'b0;
		#(HALF_NS / 3) scl = 1'b1;
		#HALF_NS sda_low = 1'b1;
		#HALF_NS scl = 1'b0;
	endtask

	// One clock: data set late in the low phase, sampled mid-high
	task automatic clock_bit(input logic b, output logic seen);
		#(HALF_NS * 2 / 3) sda_low = ~b;
		#(HALF_NS / 3) scl = 1'b1;
		#(HALF_NS / 2) seen = sda;
		#(HALF_NS / 2) scl = 1'b0;
	endtask

	// Byte out, MSB first, then the ninth clock for the slave ack
	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clock_bit(b[i], s);
		end
		clock_bit(1'b1, s);
		ack = ~s;
	endtask

	// Byte in; ack keeps the slave sending, nack ends the read
	task automatic get_byte(input logic more, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clock_bit(1'b1, s);
			b[i] = s;
		end
		clock_bit(~more, s);
	endtask

	// Stop: data rises while the clock is high, bus left idle
	task automatic stop();
		#(HALF_NS * 2 / 3) sda_low = 1'b1;
		#(HALF_NS / 3) scl = 1'b1;
		#HALF_NS sda_low = 1'b0;
		#HALF_NS;
	endtask
endmodule

//--- verif/digital_pot_register_bank_tb.sv
// Self-checking bench for the digital pot register bank
`timescale 1ns/1ns
module digital_pot_register_bank_tb;
	localparam int NV_CYC = 2000;
	logic       ref_clk;
	logic       reset;
	logic       address_select_pin;
	logic       scl;
	logic       m_low;
	logic       sda;
	logic       sda_out;
	logic       sda_oe_n;
	logic [6:0] wiper_position;
	logic       shutdown_n;
	logic       divider_mode;
	logic       precision_off;
	logic       nv_write_pending;
	int         err_count = 0;
	int         total_checks = 0;
	int         cycles = 0;
	int         stop_at = 0;

	//------------------------------------------------------
	// Harness
	//------------------------------------------------------
	// Wired-AND bus line with pull-up
	assign sda = (m_low === 1'b1) ? 1'b0 : ((sda_oe_n === 1'b0) ? sda_out : 1'b1);

	digital_pot_register_bank #(.NV_WRITE_CYCLES(NV_CYC)) DUT (
		.ref_clk(ref_clk), .reset(reset), .scl(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .address_select_pin(address_select_pin),
		.wiper_position(wiper_position), .shutdown_n(shutdown_n), .divider_mode(divider_mode),
		.precision_off(precision_off), .nv_write_pending(nv_write_pending));

	pot_bus_master master (.scl(scl), .sda_low(m_low), .sda(sda));

	// System clock
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	// Cycle count with hang guard
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 40000) begin
			err_count++;
			finish_test();
		end
	end

	task automatic finish_test();
		if (err_count == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask

	// Write transfer with the select pin low
	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		logic a0, a1, a2, was_busy;
		// Only a write that meets an idle store can launch a cycle worth timing
		was_busy = nv_write_pending;
		master.start();
		master.put_byte(8'h50, a0);
		master.put_byte(addr, a1);
		master.put_byte(data, a2);
		master.stop();
		if (was_busy !== 1'b1) begin
			stop_at = cycles;
		end
		check("write acks", 8'h07, {5'h00, a0, a1, a2});
	endtask

	// Read transfer of two bytes from one address; mask hides don't-care bits
	task automatic rd(input logic [7:0] addr, input logic [7:0] exp, input logic [7:0] m, input string name);
		logic a0, a1, a2;
		logic [7:0] b0, b1;
		master.start();
		master.put_byte(8'h50, a0);
		master.put_byte(addr, a1);
		master.start();
		master.put_byte(8'h51, a2);
		master.get_byte(1'b1, b0);
		master.get_byte(1'b0, b1);
		master.stop();
		check("read acks", 8'h07, {5'h00, a0, a1, a2});
		check(name, exp, b0 & m);
		check(name, exp, b1 & m);
	endtask

	// Wait out the self-timed write and check its length from the stop
	task automatic wait_nv();
		int n;
		n = 0;
		while (nv_write_pending !== 1'b0 && n < NV_CYC + 100) begin
			@(negedge ref_clk);
			n++;
		end
		n = cycles - stop_at;
		total_checks++;
		if (n < NV_CYC - 10 || n > NV_CYC + 4) begin
			err_count++;
			$display("unexpected pending length: expected %0d, seen %0d", NV_CYC, n);
		end
	endtask

	// Power-up: reset held, then recall from the store
	task automatic power_up(input logic [6:0] stored);
		reset <= 1'b1;
		repeat (6) @(negedge ref_clk);
		check("wiper in reset", {1'b0, pot_pkg::WIPER_POWERUP}, {1'b0, wiper_position});
		check("flags in reset", 8'h01, {6'h00, nv_write_pending, shutdown_n});
		reset <= 1'b0;
		repeat (20) @(negedge ref_clk);
		check("wiper before recall", 8'h40, {1'b0, wiper_position});
		repeat (50) @(negedge ref_clk);
		check("wiper recalled", {1'b0, stored}, {1'b0, wiper_position});
	endtask

	//------------------------------------------------------
	// Test sequence
	//------------------------------------------------------
	initial begin
		logic ack;
		logic [7:0] ids [4] = '{8'h54, 8'h50, 8'h56, 8'h74};
		logic       oks [4] = '{1'b1, 1'b0, 1'b0, 1'b0};
		reset = 1'b1;
		address_select_pin = 1'b0;
		@(negedge ref_clk);
		power_up(pot_pkg::STORE_SHIP[6:0]);
		check("mode outputs", 8'h00, {6'h00, divider_mode, precision_off});
		rd(pot_pkg::ADDR_ACCESS, 8'h40, 8'hff, "access reset");
		rd(pot_pkg::ADDR_MODE, 8'h00, 8'hc0, "mode reset");
		rd(8'h03, 8'h00, 8'hff, "unmapped read");
		wr(pot_pkg::ADDR_INIT, 8'h7f);
		check("wiper top tap", 8'h7f, {1'b0, wiper_position});
		check("pending set", 8'h01, {7'h00, nv_write_pending});
		wr(pot_pkg::ADDR_ACCESS, 8'h80);
		wr(pot_pkg::ADDR_INIT, 8'h22);
		check("wiper kept", 8'h7f, {1'b0, wiper_position});
		rd(pot_pkg::ADDR_ACCESS, 8'h60, 8'hff, "access pending");
		wait_nv();
		rd(pot_pkg::ADDR_INIT, 8'h7f, 8'hff, "store");
		wr(pot_pkg::ADDR_ACCESS, 8'hbf);
		rd(pot_pkg::ADDR_ACCESS, 8'h80, 8'hff, "access written");
		check("shutdown", 8'h00, {7'h00, shutdown_n});
		wr(pot_pkg::ADDR_INIT, 8'h15);
		check("wiper only", 8'h15, {nv_write_pending, wiper_position});
		rd(pot_pkg::ADDR_INIT, 8'h15, 8'hff, "wiper read");
		wr(pot_pkg::ADDR_MODE, 8'hff);
		wait_nv();
		check("mode outputs set", 8'h03, {6'h00, divider_mode, precision_off});
		rd(pot_pkg::ADDR_MODE, 8'hc0, 8'hc0, "mode written");
		// Select pin high: only the matching identity is acknowledged
		address_select_pin <= 1'b1;
		repeat (4) @(negedge ref_clk);
		for (int i = 0; i < 4; i++) begin
			master.start();
			master.put_byte(ids[i], ack);
			master.stop();
			check("id ack", {7'h00, oks[i]}, {7'h00, ack});
		end
		address_select_pin <= 1'b0;
		@(negedge ref_clk);
		power_up(7'h7f);
		check("mode kept", 8'h03, {6'h00, divider_mode, precision_off});
		rd(pot_pkg::ADDR_ACCESS, 8'h40, 8'hff, "access after power");
		finish_test();
	end
endmodule
